// File: testbench/ddr2_init_and_activate_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ddr2_init_and_activate_bench;
  import dia_pkg::*;
  localparam int PWR = 50;
  logic clk, rst, cke, term, rd, wr, waitreq, init_done, ready, term_on, viol_any;
  logic [3:0] cmd;
  logic [2:0] ba;
  logic [15:0] addr;
  logic [4:0] avs_addr;
  logic [31:0] wdata, rdata;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  dia_ctl_model i_ctl (.i_clk(clk), .o_cke(cke), .o_cmd(cmd), .o_term(term), .o_ba(ba),
    .o_addr(addr));
  dia_core #(.P_PWR_CYC(PWR)) i_dut (.I_MCLK(clk), .I_RST(rst), .I_CKE(cke),
    .I_CS_N(cmd[3]), .I_RAS_N(cmd[2]), .I_CAS_N(cmd[1]), .I_WE_N(cmd[0]),
    .I_TERM_CTRL(term), .I_BA(ba), .I_ADDR(addr), .I_AVS_ADDRESS(avs_addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .O_INIT_DONE(init_done),
    .O_READY(ready), .O_TERM_ON(term_on), .O_VIOL_ANY(viol_any));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag
  // avalon access held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    // waitrequest read right after the edge is the value sampled at that edge
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (waitreq !== 1'b0) begin
      num_errors++;
      $display("ERROR %0t bus hang", $time);
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rd_exp(input logic [4:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask : rd_exp
  // let the pin synchroniser catch up, check the flags, then clear them
  task automatic viol(input logic [31:0] exp);
    repeat (4) @(posedge clk);
    rd_exp(DIA_OFS_VIOL, exp);
    bus(1'b1, DIA_OFS_VIOL, 32'h00001FFF);
  endtask : viol
  // read data taken at the edge where waitrequest is sampled low
  always @(posedge clk) begin
    if (rd && waitreq === 1'b0) check_word(rdata, exp_q.pop_front());
  end
  // hang guard, the whole run is well under 1000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    avs_addr = 5'h00;
    wdata = 32'h0;
    void'($urandom(32'h755671E3));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_exp(DIA_OFS_CTRL, 32'h00000001);
    rd_exp(5'h1C, 32'h0);
    i_ctl.init(PWR);
    rd_exp(DIA_OFS_STATUS, 32'h000000C0);
    check_flag(ready, 1'b0);
    check_flag(init_done, 1'b1);
    rd_exp(DIA_OFS_EXTENDED_MODE_REGISTER_2, 32'h00000080);
    bus(1'b1, DIA_OFS_EXTENDED_MODE_REGISTER_3, 32'h00001FFF);
    rd_exp(DIA_OFS_EXTENDED_MODE_REGISTER_3, 32'h0);
    rd_exp(DIA_OFS_MR, 32'h00000032);
    rd_exp(DIA_OFS_EMR1, 32'h00000004);
    rd_exp(DIA_OFS_VIOL, 32'h0);
    repeat (200) @(posedge clk);
    check_flag(ready, 1'b1);
    // five activates on consecutive edges: one too many for the window
    for (int b = 0; b < 5; b++) i_ctl.cmd(DIA_CMD_ACT, b[2:0], 16'($urandom), b / 4);
    viol(32'h00001000);
    i_ctl.cmd(DIA_CMD_RD, 3'h5, 16'h0, 1);
    viol(32'h00000100);
    i_ctl.cmd(DIA_CMD_ACT, 3'h6, 16'($urandom), 0);
    i_ctl.cmd(DIA_CMD_RD, 3'h6, 16'h0, 1);
    viol(32'h00000200);
    i_ctl.cmd(DIA_CMD_ACT, 3'h0, 16'($urandom), 1);
    viol(32'h00000400);
    i_ctl.cmd(DIA_CMD_PRE, 3'h0, 16'h0, 8);
    i_ctl.cmd(DIA_CMD_ACT, 3'h0, 16'($urandom), 1);
    viol(32'h0);
    // termination follows its pin once extended register 1 enables it
    i_ctl.term(1'b1);
    repeat (4) @(posedge clk);
    check_flag(term_on, 1'b1);
    i_ctl.term(1'b0);
    bus(1'b1, DIA_OFS_CTRL, 32'h0);
    i_ctl.cmd(DIA_CMD_ACT, 3'h0, 16'($urandom), 1);
    viol(32'h0);
    check_flag(viol_any, 1'b0);
    check_flag(term_on, 1'b0);
    finish_test();
  end
endmodule : ddr2_init_and_activate_bench
`default_nettype wire

// File: testbench/dia_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
// controller stand-in driving the memory command pins
module dia_ctl_model import dia_pkg::*; (
  // clock
  input wire logic i_clk,
  // command pins, o_cmd is {cs_n, ras_n, cas_n, we_n}
  output logic o_cke,
  output logic [3:0] o_cmd,
  output logic o_term,
  output logic [DIA_BA_W-1:0] o_ba,
  output logic [DIA_A_W-1:0] o_addr
);
  // power-up levels
  initial begin
    o_cke = 1'b0;
    o_cmd = DIA_CMD_NOP;
    o_term = 1'b0;
    o_ba = '0;
    o_addr = '0;
  end
  // one command; gap 0 leaves the next command back to back
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                     input int gap);
    @(posedge i_clk);
    o_cmd <= c;
    o_ba <= b;
    o_addr <= a;
    if (gap > 0) begin
      @(posedge i_clk);
      o_cmd <= DIA_CMD_NOP;
      // inverted lines so a stale address is never mistaken for a live one
      o_ba <= ~b;
      o_addr <= ~a;
      repeat (gap - 1) @(posedge i_clk);
    end
  endtask : cmd
  // termination pin, changed just after an edge
  task automatic term(input logic t);
    @(posedge i_clk);
    o_term <= t;
  endtask : term
  // power-up sequence; every load leaves 3 cycles, above tMRD
  task automatic init(input int pwr);
    repeat (pwr + 5) @(posedge i_clk);
    o_cke <= 1'b1;
    repeat (45) @(posedge i_clk);
    cmd(DIA_CMD_PRE, 3'h0, 16'h0400, 3);
    cmd(DIA_CMD_LM, 3'h2, 16'h0080, 3);
    cmd(DIA_CMD_LM, 3'h3, 16'h0000, 3);
    cmd(DIA_CMD_LM, 3'h1, 16'h0000, 3);
    cmd(DIA_CMD_LM, 3'h0, 16'h0100, 3);
    cmd(DIA_CMD_PRE, 3'h0, 16'h0400, 3);
    cmd(DIA_CMD_REF, 3'h0, 16'h0000, 3);
    cmd(DIA_CMD_REF, 3'h0, 16'h0000, 3);
    cmd(DIA_CMD_LM, 3'h0, 16'h0032, 3);
    cmd(DIA_CMD_LM, 3'h1, 16'h0380, 3);
    cmd(DIA_CMD_LM, 3'h1, 16'h0004, 3);
  endtask : init
endmodule : dia_ctl_model
`default_nettype wire

// File: verilog/dia_bank.sv
`timescale 1ns/10ps
`default_nettype none
module dia_bank #(
  parameter int IDX = 0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // decoded commands
  dia_cmd_if.dst cmd,
  // bank state
  output logic o_open,
  output logic o_trc_ok,
  output logic o_trcd_ok
);
  import dia_pkg::*;
  localparam logic [7:0] TRC_C = 8'(DIA_TRC_CYC);
  localparam logic [7:0] TRCD_C = 8'(DIA_TRCD_CYC);

  if (IDX < 0 || IDX >= DIA_NBANK || DIA_TRC_CYC > 255 || DIA_TRCD_CYC > 255) begin : g_chk
    $error("dia_bank index or timing out of range");
  end

  typedef struct packed {
    logic open;
    logic [7:0] rc;
    logic [7:0] rcd;
  } dia_bank_t;

  dia_bank_t st;
  dia_bank_t next_st;
  logic hit;

  assign hit = (cmd.bank == DIA_BA_W'(IDX));

  // open-row flag and spacing counters since this bank's last activate
  always_comb begin
    next_st = st;
    if (st.rc != 8'h00) begin
      next_st.rc = st.rc - 8'h01;
    end
    if (st.rcd != 8'h00) begin
      next_st.rcd = st.rcd - 8'h01;
    end
    if (cmd.act && hit) begin
      next_st.open = 1'b1; // R23
      next_st.rc = TRC_C - 8'h01; // R20
      next_st.rcd = TRCD_C - 8'h01; // R19
    end else if (cmd.pre && (hit || cmd.pre_all)) begin
      next_st.open = 1'b0; // R17
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_open = st.open;
  assign o_trc_ok = (st.rc == 8'h00);
  assign o_trcd_ok = (st.rcd == 8'h00);
endmodule : dia_bank
`default_nettype wire

// File: verilog/dia_cmd_if.sv
`timescale 1ns/10ps
`default_nettype none
// decoded row commands broadcast to every bank tracker
interface dia_cmd_if;
  import dia_pkg::*;
  logic act;
  logic pre;
  logic pre_all;
  logic [DIA_BA_W-1:0] bank;
  modport src (output act, output pre, output pre_all, output bank);
  modport dst (input act, input pre, input pre_all, input bank);
endinterface : dia_cmd_if
`default_nettype wire

// File: verilog/dia_core.sv
// Notes on behaviour
// R1: extended mode register 3 bits stay reserved, kept until reloaded, array untouched.
// R2: load extended register 3 only with banks idle; wait tMRD afterwards.
// R3: extended register 3 loads carry zero in E16 and above E12.
// R4: termination control stays low during power-up.
// R5: once raised during initialization, CKE stays high until it ends.
// R6: only NOP or deselect for 200us after stable power, then CKE high.
// R7: wait at least 400ns after CKE high, then precharge all.
// R8: load extended register 2 next; only E7 may be set.
// R9: load extended register 3 next with all bits zero.
// R10: load extended register 1 with A0 low to enable the DLL.
// R11: mode load with A8 high resets DLL; lock takes 200 cycles.
// R12: after DLL reset, precharge all then two or more refreshes.
// R13: mode load with A8 low sets operating parameters.
// R14: extended register 1 load with E7..E9 all ones: calibration default.
// R15: extended register 1 load with E7..E9 zero leaves calibration.
// R16: normal operation no earlier than 200 cycles after DLL reset.
// R17: precharge with A10 high closes all banks; bank pins pick register.
// R18: a bank needs an activate before any read or write.
// R19: timing limits round up to cycles; read or write waits tRCD.
// R20: new row in same bank needs precharge and tRC since activate.
// R21: activates to different banks are spaced by at least tRRD.
// R22: at most four activates within any rolling tFAW window.
// R23: per-bank open state and counters check each command's legality.
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dia_core #(
  parameter int P_PWR_CYC = dia_pkg::DIA_PWR_CYC
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_RST,
  // memory command pins
  input wire logic I_CKE,
  input wire logic I_CS_N,
  input wire logic I_RAS_N,
  input wire logic I_CAS_N,
  input wire logic I_WE_N,
  input wire logic I_TERM_CTRL,
  input wire logic [dia_pkg::DIA_BA_W-1:0] I_BA,
  input wire logic [dia_pkg::DIA_A_W-1:0] I_ADDR,
  // avalon-mm slave
  input wire logic [dia_pkg::DIA_AVS_AW-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // status
  output logic O_INIT_DONE,
  output logic O_READY,
  output logic O_TERM_ON,
  output logic O_VIOL_ANY
);
  import dia_pkg::*;
  localparam int PW = 6 + DIA_BA_W + DIA_A_W;
  localparam logic [15:0] PWR_C = 16'(P_PWR_CYC);
  localparam logic [15:0] CKE_C = 16'(DIA_CKE_CYC);
  localparam logic [7:0] LOCK_C = 8'(DIA_DLL_LOCK_CYC);
  localparam logic [7:0] MRD_C = 8'(DIA_MRD_CYC);
  localparam logic [7:0] RRD_C = 8'(DIA_TRRD_CYC);
  localparam logic [7:0] FAW_C = 8'(DIA_TFAW_CYC);

  if (P_PWR_CYC < 1 || P_PWR_CYC > 65535 || DIA_TFAW_CYC > 254 || DIA_MRD_CYC < 1
      || DIA_TRRD_CYC > 255 || DIA_DLL_LOCK_CYC > 255) begin : g_chk
    $error("dia_core timing does not fit its counters");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic check_en;
    logic [3:0][DIA_MODE_W-1:0] mode;
    logic emr1_seen;
    dia_init_t init;
    logic [15:0] wait_cnt;
    logic cke_d;
    logic [7:0] mrd_cnt;
    logic dll_rst_seen;
    logic [7:0] lock_cnt;
    logic ready;
    logic term_on;
    logic [7:0] rrd_cnt;
    logic [DIA_BA_W-1:0] last_bank;
    logic [3:0] faw_vld;
    logic [3:0][7:0] faw_age;
    logic [DIA_VIOL_W-1:0] viol;
  } dia_core_t;

  dia_core_t st;
  dia_core_t next_st;

  // command pins arrive on the memory clock's pins; two stages before decode
  logic [PW-1:0] pins_s;
  dia_sync #(.W(PW)) u_sync (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_d({I_CKE, I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_TERM_CTRL, I_BA, I_ADDR}),
    .o_q(pins_s)
  );

  logic cke_s;
  logic odt_s;
  logic [3:0] cmd_s;
  logic [DIA_BA_W-1:0] ba_s;
  logic [DIA_A_W-1:0] a_s;
  logic [DIA_MODE_W-1:0] a_mode;
  logic [1:0] sel;
  logic a10;
  assign cke_s = pins_s[PW-1];
  assign cmd_s = pins_s[PW-2 -: 4];
  assign odt_s = pins_s[PW-6];
  assign ba_s = pins_s[DIA_A_W +: DIA_BA_W];
  assign a_s = pins_s[DIA_A_W-1:0];
  assign a_mode = a_s[DIA_MODE_W-1:0];
  assign sel = ba_s[1:0];
  assign a10 = a_s[DIA_BIT_A10];

  // command decode, ignored while clock enable is low
  logic is_lm, is_ref, is_pre, is_act, is_rd, is_wr, is_any;
  assign is_lm = cke_s && (cmd_s == DIA_CMD_LM);
  assign is_ref = cke_s && (cmd_s == DIA_CMD_REF);
  assign is_pre = cke_s && (cmd_s == DIA_CMD_PRE);
  assign is_act = cke_s && (cmd_s == DIA_CMD_ACT);
  assign is_rd = cke_s && (cmd_s == DIA_CMD_RD);
  assign is_wr = cke_s && (cmd_s == DIA_CMD_WR);
  assign is_any = cke_s && !cmd_s[3] && (cmd_s != DIA_CMD_NOP);

  // bank trackers share one decoded command stream
  dia_cmd_if u_cmd ();
  assign u_cmd.act = is_act;
  assign u_cmd.pre = is_pre;
  assign u_cmd.pre_all = is_pre && a10; // R17
  assign u_cmd.bank = ba_s;

  logic [DIA_NBANK-1:0] open_v;
  logic [DIA_NBANK-1:0] trc_ok_v;
  logic [DIA_NBANK-1:0] trcd_ok_v;
  for (genvar b = 0; b < DIA_NBANK; b++) begin : g_bank
    dia_bank #(.IDX(b)) u_bank (
      .i_clk(I_MCLK),
      .i_rst(I_RST),
      .cmd(u_cmd),
      .o_open(open_v[b]),
      .o_trc_ok(trc_ok_v[b]),
      .o_trcd_ok(trcd_ok_v[b])
    );
  end

  logic req;
  logic wr_go;
  logic dll_locked;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [DIA_VIOL_W-1:0] set_v;
  logic [DIA_VIOL_W-1:0] viol_clr;
  logic step;
  dia_init_t nxt_init;

  assign req = I_AVS_READ || I_AVS_WRITE;
  assign wr_go = I_AVS_WRITE && st.ack;
  assign dll_locked = st.dll_rst_seen && (st.lock_cnt == 8'h00);
  assign wmask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
                  {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

  // register read mux; unmapped offsets read zero
  always_comb begin
    case (I_AVS_ADDRESS)
      DIA_OFS_MR: rd_mux = {19'h00000, st.mode[0]};
      DIA_OFS_EMR1: rd_mux = {19'h00000, st.mode[1]};
      DIA_OFS_EXTENDED_MODE_REGISTER_2: rd_mux = {19'h00000, st.mode[2]};
      DIA_OFS_EXTENDED_MODE_REGISTER_3: rd_mux = {19'h00000, st.mode[3]}; // R1
      DIA_OFS_STATUS: rd_mux = {16'h0000, open_v, st.init, 1'b0, st.term_on, dll_locked,
                                st.ready};
      DIA_OFS_VIOL: rd_mux = {19'h00000, st.viol};
      DIA_OFS_CTRL: rd_mux = {31'h00000000, st.check_en};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // initialization progress: which command the sequence expects next
  always_comb begin
    step = 1'b0;
    nxt_init = st.init;
    case (st.init)
      DIA_ST_WAIT_PREA: begin
        step = is_pre && a10; // R7
        nxt_init = DIA_ST_EXTENDED_MODE_REGISTER_2;
      end
      DIA_ST_EXTENDED_MODE_REGISTER_2: begin
        step = is_lm && (sel == 2'h2); // R8
        nxt_init = DIA_ST_EXTENDED_MODE_REGISTER_3;
      end
      DIA_ST_EXTENDED_MODE_REGISTER_3: begin
        step = is_lm && (sel == 2'h3); // R9
        nxt_init = DIA_ST_EMR1_DLL;
      end
      DIA_ST_EMR1_DLL: begin
        step = is_lm && (sel == 2'h1) && !a_s[DIA_BIT_DLLEN]; // R10
        nxt_init = DIA_ST_MR_DLLRST;
      end
      DIA_ST_MR_DLLRST: begin
        step = is_lm && (sel == 2'h0) && a_s[DIA_BIT_DLLRST]; // R11
        nxt_init = DIA_ST_PREA2;
      end
      DIA_ST_PREA2: begin
        step = is_pre && a10; // R12
        nxt_init = DIA_ST_REF1;
      end
      DIA_ST_REF1: begin
        step = is_ref; // R12
        nxt_init = DIA_ST_REF2;
      end
      DIA_ST_REF2: begin
        step = is_ref;
        nxt_init = DIA_ST_REF_MORE;
      end
      DIA_ST_REF_MORE: begin
        step = is_ref || (is_lm && (sel == 2'h0) && !a_s[DIA_BIT_DLLRST]); // R13
        nxt_init = is_ref ? DIA_ST_REF_MORE : DIA_ST_CAL_DEF;
      end
      DIA_ST_CAL_DEF: begin
        step = is_lm && (sel == 2'h1) && (a_s[DIA_CAL_LSB +: 3] == 3'h7); // R14
        nxt_init = DIA_ST_CAL_EXIT;
      end
      DIA_ST_CAL_EXIT: begin
        step = is_lm && (sel == 2'h1) && (a_s[DIA_CAL_LSB +: 3] == 3'h0); // R15
        nxt_init = DIA_ST_DONE;
      end
      default: begin
        step = 1'b0;
        nxt_init = st.init;
      end
    endcase
  end

  // main state update: bus, mode registers, sequence checks, activate spacing
  always_comb begin
    next_st = st;
    set_v = '0;
    viol_clr = '0;
    // one wait state per access; data stands while waitrequest is low
    next_st.ack = req && !st.ack;
    if (req && !st.ack) begin
      next_st.rdata = rd_mux;
    end
    if (wr_go && (I_AVS_ADDRESS == DIA_OFS_CTRL) && I_AVS_BYTEENABLE[0]) begin
      next_st.check_en = I_AVS_WRITEDATA[0];
    end
    if (wr_go && (I_AVS_ADDRESS == DIA_OFS_VIOL)) begin
      viol_clr = I_AVS_WRITEDATA[DIA_VIOL_W-1:0] & wmask[DIA_VIOL_W-1:0];
    end
    // power-up wait and clock-enable supervision
    next_st.cke_d = cke_s;
    if (st.wait_cnt != 16'hFFFF) begin
      next_st.wait_cnt = st.wait_cnt + 16'h0001;
    end
    if (st.init == DIA_ST_WAIT_CKE) begin
      if (cke_s) begin
        next_st.init = DIA_ST_WAIT_PREA;
        next_st.wait_cnt = 16'h0000;
        set_v[DIA_V_TIME] = (st.wait_cnt < PWR_C); // R6
      end
    end else if (step) begin
      next_st.init = nxt_init;
      if (st.init == DIA_ST_WAIT_PREA) begin
        set_v[DIA_V_TIME] = (st.wait_cnt < CKE_C); // R7
      end
    end else if (is_any && (st.init != DIA_ST_DONE)) begin
      set_v[DIA_V_ORDER] = 1'b1; // R12
    end
    if (st.cke_d && !cke_s && (st.init != DIA_ST_WAIT_CKE) && (st.init != DIA_ST_DONE)) begin
      set_v[DIA_V_CKE] = 1'b1; // R5
    end
    set_v[DIA_V_ODT] = odt_s && !st.emr1_seen; // R4
    // mode register spacing and content
    if (st.mrd_cnt != 8'h00) begin
      next_st.mrd_cnt = st.mrd_cnt - 8'h01;
    end
    set_v[DIA_V_MRD] = is_any && (st.mrd_cnt != 8'h00); // R2
    if (is_lm) begin
      next_st.mode[sel] = a_mode; // R17
      next_st.mrd_cnt = MRD_C - 8'h01;
      set_v[DIA_V_BUSY] = (open_v != '0); // R2
      set_v[DIA_V_RSVD] = ba_s[2] || (a_s[DIA_A_W-1:DIA_MODE_W] != '0) // R3
        || ((st.init != DIA_ST_DONE) && (sel == 2'h2) && ((a_s & ~DIA_EXTENDED_MODE_REGISTER_2_SRF_MASK) != '0))
        || ((st.init != DIA_ST_DONE) && (sel == 2'h3) && (a_s != '0)); // R9
      if (sel == 2'h1) begin
        next_st.emr1_seen = 1'b1;
      end
    end
    // dll lock countdown restarts on every reset request
    if (st.lock_cnt != 8'h00) begin
      next_st.lock_cnt = st.lock_cnt - 8'h01;
    end
    if (is_lm && (sel == 2'h0) && a_s[DIA_BIT_DLLRST]) begin
      next_st.dll_rst_seen = 1'b1;
      next_st.lock_cnt = LOCK_C; // R11
    end
    // row commands against bank state
    if (is_act || is_rd || is_wr) begin
      set_v[DIA_V_EARLY] = !st.ready; // R16
    end
    if (is_rd || is_wr) begin
      set_v[DIA_V_CLOSED] = !open_v[ba_s]; // R18
      set_v[DIA_V_TRCD] = open_v[ba_s] && !trcd_ok_v[ba_s]; // R19
    end
    // ages saturate, so a long idle gap never looks like a recent activate
    for (int i = 0; i < 4; i++) begin
      if (st.faw_age[i] != 8'hFF) begin
        next_st.faw_age[i] = st.faw_age[i] + 8'h01;
      end
    end
    if (st.rrd_cnt != 8'h00) begin
      next_st.rrd_cnt = st.rrd_cnt - 8'h01;
    end
    if (is_act) begin
      set_v[DIA_V_TRC] = open_v[ba_s] || !trc_ok_v[ba_s]; // R20
      set_v[DIA_V_TRRD] = (st.rrd_cnt != 8'h00) && (ba_s != st.last_bank); // R21
      set_v[DIA_V_TFAW] = st.faw_vld[3] && (st.faw_age[3] < FAW_C); // R22
      // shift the already aged values, so a shift never loses a cycle of age
      next_st.faw_age = {next_st.faw_age[2:0], 8'h01};
      next_st.faw_vld = {st.faw_vld[2:0], 1'b1};
      next_st.rrd_cnt = RRD_C - 8'h01; // R21
      next_st.last_bank = ba_s;
    end
    // termination takes effect only once extended register 1 has been loaded
    next_st.term_on = odt_s && st.emr1_seen
      && (st.mode[1][DIA_BIT_RTT0] || st.mode[1][DIA_BIT_RTT1]);
    // set wins over a same-cycle clear
    next_st.viol = (st.viol & ~viol_clr) | (set_v & {DIA_VIOL_W{st.check_en}});
    next_st.ready = (next_st.init == DIA_ST_DONE) && next_st.dll_rst_seen
      && (next_st.lock_cnt == 8'h00); // R16
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      st <= '0;
      st.check_en <= DIA_CTRL_RST;
      st.init <= DIA_ST_WAIT_CKE;
    end else begin
      st <= next_st;
    end
  end

  assign O_AVS_READDATA = st.rdata;
  assign O_AVS_WAITREQUEST = req && !st.ack;
  assign O_INIT_DONE = (st.init == DIA_ST_DONE);
  assign O_READY = st.ready;
  assign O_TERM_ON = st.term_on;
  assign O_VIOL_ANY = |st.viol;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  sequence s_dll_rst;
    is_lm && (sel == 2'h0) && a_s[DIA_BIT_DLLRST];
  endsequence
  sequence s_fifth_act_early;
    is_act && st.faw_vld[3] && (st.faw_age[3] < FAW_C) && st.check_en;
  endsequence

  a_dll_lock_wait: assert property (s_dll_rst |=> (!st.ready) [*8]) // R11
    else $error("ready too soon after dll reset");
  a_ready_source: assert property ($rose(st.ready) |-> ($past(st.lock_cnt) == 8'h01) // R16
    || ($past(st.init) != DIA_ST_DONE))
    else $error("ready rose without lock countdown");
  a_ready_done: assert property (st.ready |-> (st.init == DIA_ST_DONE) && dll_locked) // R16
    else $error("ready outside completed sequence");
  a_prea_close: assert property (is_pre && a10 |=> open_v == '0) // R17
    else $error("precharge all left a bank open");
  a_mode_load: assert property (is_lm |=> st.mode[$past(sel)] == $past(a_mode)) // R17
    else $error("mode load landed in wrong register");
  a_extended_mode_register_3_hold: assert property (!$stable(st.mode[3]) |-> $past(is_lm) && $past(sel) == 2'h3) // R1
    else $error("extended register 3 changed without load");
  a_flag_sticky: assert property (1'b1 |=> (($past(st.viol) & ~$past(viol_clr)) & ~st.viol) == '0)
    else $error("violation flag lost without clear");
  a_trrd_flag: assert property (is_act && (st.rrd_cnt != 8'h00) && (ba_s != st.last_bank)
    && st.check_en |=> st.viol[DIA_V_TRRD]) // R21
    else $error("activate spacing breach not flagged");
  a_tfaw_flag: assert property (s_fifth_act_early |=> st.viol[DIA_V_TFAW]) // R22
    else $error("fifth activate in window not flagged");
  a_odt_early: assert property (odt_s && !st.emr1_seen && st.check_en |=> st.viol[DIA_V_ODT]) // R4
    else $error("early termination not flagged");
  a_bus_wait: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("bus access held off more than one cycle");
endmodule : dia_core
`default_nettype wire

// File: verilog/dia_core_dummy_guard.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: verilog/dia_pkg.sv
`default_nettype none
package dia_pkg;
  // clock rate and derived cycle counts, minimum times rounded up
  localparam int DIA_CLK_MHZ = 100;
  localparam int DIA_PWR_US = 200;
  localparam int DIA_PWR_CYC = DIA_PWR_US * DIA_CLK_MHZ;
  localparam int DIA_CKE_NS = 400;
  localparam int DIA_CKE_CYC = (DIA_CKE_NS * DIA_CLK_MHZ + 999) / 1000;
  localparam int DIA_DLL_LOCK_CYC = 200;
  localparam int DIA_MRD_CYC = 2;
  localparam int DIA_TRCD_NS = 15;
  localparam int DIA_TRCD_CYC = (DIA_TRCD_NS * DIA_CLK_MHZ + 999) / 1000;
  localparam int DIA_TRC_NS = 55;
  localparam int DIA_TRC_CYC = (DIA_TRC_NS * DIA_CLK_MHZ + 999) / 1000;
  localparam int DIA_TRRD_NS = 10;
  localparam int DIA_TRRD_CYC = (DIA_TRRD_NS * DIA_CLK_MHZ + 999) / 1000;
  localparam int DIA_TFAW_NS = 50;
  localparam int DIA_TFAW_CYC = (DIA_TFAW_NS * DIA_CLK_MHZ + 999) / 1000;
  // widths
  localparam int DIA_BA_W = 3;
  localparam int DIA_A_W = 16;
  localparam int DIA_MODE_W = 13;
  localparam int DIA_NBANK = 8;
  localparam int DIA_VIOL_W = 13;
  localparam int DIA_AVS_AW = 5;
  // register byte offsets
  localparam logic [4:0] DIA_OFS_MR = 5'h00;
  localparam logic [4:0] DIA_OFS_EMR1 = 5'h04;
  localparam logic [4:0] DIA_OFS_EXTENDED_MODE_REGISTER_2 = 5'h08;
  localparam logic [4:0] DIA_OFS_EXTENDED_MODE_REGISTER_3 = 5'h0C;
  localparam logic [4:0] DIA_OFS_STATUS = 5'h10;
  localparam logic [4:0] DIA_OFS_VIOL = 5'h14;
  localparam logic [4:0] DIA_OFS_CTRL = 5'h18;
  localparam logic DIA_CTRL_RST = 1'b1;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] DIA_CMD_LM = 4'h0;
  localparam logic [3:0] DIA_CMD_REF = 4'h1;
  localparam logic [3:0] DIA_CMD_PRE = 4'h2;
  localparam logic [3:0] DIA_CMD_ACT = 4'h3;
  localparam logic [3:0] DIA_CMD_WR = 4'h4;
  localparam logic [3:0] DIA_CMD_RD = 4'h5;
  localparam logic [3:0] DIA_CMD_NOP = 4'h7;
  // address bit positions and field masks
  localparam int DIA_BIT_DLLEN = 0;
  localparam int DIA_BIT_RTT0 = 2;
  localparam int DIA_BIT_RTT1 = 6;
  localparam int DIA_BIT_DLLRST = 8;
  localparam int DIA_BIT_A10 = 10;
  localparam int DIA_CAL_LSB = 7;
  localparam logic [15:0] DIA_EXTENDED_MODE_REGISTER_2_SRF_MASK = 16'h0080;
  // violation flag positions
  localparam int DIA_V_ORDER = 0;
  localparam int DIA_V_TIME = 1;
  localparam int DIA_V_CKE = 2;
  localparam int DIA_V_ODT = 3;
  localparam int DIA_V_MRD = 4;
  localparam int DIA_V_BUSY = 5;
  localparam int DIA_V_RSVD = 6;
  localparam int DIA_V_EARLY = 7;
  localparam int DIA_V_CLOSED = 8;
  localparam int DIA_V_TRCD = 9;
  localparam int DIA_V_TRC = 10;
  localparam int DIA_V_TRRD = 11;
  localparam int DIA_V_TFAW = 12;
  // initialization progress
  typedef enum logic [3:0] {
    DIA_ST_WAIT_CKE = 4'h0,
    DIA_ST_WAIT_PREA = 4'h1,
    DIA_ST_EXTENDED_MODE_REGISTER_2 = 4'h2,
    DIA_ST_EXTENDED_MODE_REGISTER_3 = 4'h3,
    DIA_ST_EMR1_DLL = 4'h4,
    DIA_ST_MR_DLLRST = 4'h5,
    DIA_ST_PREA2 = 4'h6,
    DIA_ST_REF1 = 4'h7,
    DIA_ST_REF2 = 4'h8,
    DIA_ST_REF_MORE = 4'h9,
    DIA_ST_CAL_DEF = 4'hA,
    DIA_ST_CAL_EXIT = 4'hB,
    DIA_ST_DONE = 4'hC
  } dia_init_t;
endpackage : dia_pkg
`default_nettype wire

// File: verilog/dia_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dia_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  if (W < 1) begin : g_chk
    $error("dia_sync width must be positive");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } dia_sync_t;

  dia_sync_t st;
  dia_sync_t next_st;

  // meta stage feeds only the second stage
  always_comb begin
    next_st.meta = i_d;
    next_st.q = st.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.q;
endmodule : dia_sync
`default_nettype wire
